// ===== logic/video_adjust_and_noise_reduction.sv
`timescale 1ns/1ps
`include "video_adjust_defines.svh"

module video_adjust_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
        count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

module video_adjust_and_noise_reduction
    import video_adjust_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    output logic [7:0] reg_rdata,
    input wire logic [2:0] luma_filter_select,
    input wire logic sharpness_filter_enable,
    input wire logic in_valid,
    input wire video_in_t in_data,
    output logic in_ready,
    output logic out_valid,
    output video_out_t out_data,
    input wire logic out_ready
);
    function automatic logic near_edge(input logic [4:0] pos, input logic [4:0] size,
                                       input logic [4:0] half);
        near_edge = (pos < half) || (pos >= 5'(size - half));
    endfunction

    function automatic logic signed [9:0] clamp_signed(input logic signed [18:0] val);
        if (val > 19'sd511) begin
            clamp_signed = 10'sd511;
        end else if (val < -19'sd512) begin
            clamp_signed = -10'sd512;
        end else begin
            clamp_signed = val[9:0];
        end
    endfunction

    // register file
    logic [7:0] u_gain;
    logic [7:0] v_gain;
    logic [7:0] hue_shift;
    logic [7:0] brightness_offset;
    logic [3:0] sharpness_select;
    logic [7:0] noise_coring_gains;
    logic [7:0] noise_threshold_block;
    noise_mode_t noise_mode_sel;
    logic [7:0] rd_mux;

    always_ff @(posedge clk) begin
        if (rst) begin
            u_gain <= `RST_U_GAIN;
            v_gain <= `RST_V_GAIN;
            hue_shift <= `RST_HUE_SHIFT;
            brightness_offset <= `RST_BRIGHTNESS;
            sharpness_select <= `RST_SHARPNESS;
            noise_coring_gains <= `RST_CORING_GAINS;
            noise_threshold_block <= `RST_THRESHOLD_BLOCK;
            noise_mode_sel <= NOISE_PLAIN;
        end else if (reg_we) begin
            case (reg_addr)
                `OFS_U_GAIN: u_gain <= reg_wdata;
                `OFS_V_GAIN: v_gain <= reg_wdata;
                `OFS_HUE_SHIFT: hue_shift <= reg_wdata;
                `OFS_BRIGHTNESS: brightness_offset <= reg_wdata;
                `OFS_SHARPNESS: sharpness_select <= reg_wdata[3:0];
                `OFS_CORING_GAINS: noise_coring_gains <= reg_wdata;
                `OFS_THRESHOLD_BLOCK: noise_threshold_block <= reg_wdata;
                `OFS_NOISE_MODE: noise_mode_sel <= noise_mode_t'(reg_wdata[`NOISE_MODE_BIT]);
                default: ;
            endcase
        end
    end

    assign rd_mux = (reg_addr == `OFS_U_GAIN) ? u_gain :
                    (reg_addr == `OFS_V_GAIN) ? v_gain :
                    (reg_addr == `OFS_HUE_SHIFT) ? hue_shift :
                    (reg_addr == `OFS_BRIGHTNESS) ? brightness_offset :
                    (reg_addr == `OFS_SHARPNESS) ? {4'h0, sharpness_select} :
                    (reg_addr == `OFS_CORING_GAINS) ? noise_coring_gains :
                    (reg_addr == `OFS_THRESHOLD_BLOCK) ? noise_threshold_block :
                    (reg_addr == `OFS_NOISE_MODE) ? {4'h0, noise_mode_sel, 3'h0} : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rd_mux;
        end
    end

    // pixel pace: one enable every two clocks
    logic [1:0] pace_cnt;
    logic pix_en;

    always_ff @(posedge clk) begin
        if (rst) begin
            pace_cnt <= 2'h0;
            pix_en <= 1'b0;
        end else begin
            pace_cnt <= (pace_cnt == 2'(`CLKS_PER_PIXEL - 1)) ? 2'h0 : 2'(pace_cnt + 1'b1);
            pix_en <= (pace_cnt == 2'(`CLKS_PER_PIXEL - 1));
        end
    end

    // input buffer
    logic fifo_valid;
    video_in_t head;
    logic fire;

    video_adjust_fifo #(
        .WIDTH($bits(video_in_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(in_valid),
        .in_data(in_data),
        .in_ready(in_ready),
        .out_valid(fifo_valid),
        .out_data(head),
        .out_ready(fire)
    );

    assign fire = pix_en && fifo_valid && (!out_valid || out_ready);

    // block position tracking
    logic [4:0] col_r;
    logic [4:0] row_r;
    logic [9:0] prev_y;
    wire [4:0] block_size = noise_threshold_block[`BLOCK_SIZE_BIT] ?
                            `LARGE_BLOCK : `SMALL_BLOCK;
    wire [4:0] half_border = noise_threshold_block[`BORDER_WIDTH_BIT] ?
                             5'h02 : 5'h01;
    wire [4:0] row_step = (5'(row_r + 1'b1) == block_size) ? 5'h00 : 5'(row_r + 1'b1);
    wire [4:0] cur_col = head.line_start ? 5'h00 : col_r;
    wire [4:0] cur_row = head.frame_start ? 5'h00 : (head.line_start ? row_step : row_r);
    wire [4:0] col_step = (5'(cur_col + 1'b1) == block_size) ? 5'h00 : 5'(cur_col + 1'b1);
    wire in_border = near_edge(cur_col, block_size, half_border) ||
                     near_edge(cur_row, block_size, half_border);

    always_ff @(posedge clk) begin
        if (rst) begin
            col_r <= 5'h00;
            row_r <= 5'h00;
            prev_y <= 10'h000;
        end else if (fire) begin
            col_r <= col_step;
            row_r <= cur_row;
            prev_y <= head.y;
        end
    end

    // detail filter and noise coring
    wire signed [10:0] diff_y = $signed({1'b0, head.y}) -
                                $signed({1'b0, (head.line_start ? head.y : prev_y)});
    wire signed [10:0] detail = diff_y >>> 1;
    wire [10:0] detail_mag = detail[10] ? 11'(-detail) : 11'(detail);
    wire [5:0] threshold = noise_threshold_block[`THRESHOLD_LSB +: 6];
    wire [3:0] raw_gain = in_border ? noise_coring_gains[`BORDER_GAIN_LSB +: 4] :
                          noise_coring_gains[`INNER_GAIN_LSB +: 4];
    wire [3:0] core_gain = (raw_gain > `CORE_GAIN_MAX) ? `CORE_GAIN_MAX : raw_gain;
    wire signed [15:0] core_prod = 16'(detail * $signed({1'b0, core_gain}));
    wire below = detail_mag < {5'h00, threshold};
    wire above = detail_mag > {5'h00, threshold};
    wire signed [15:0] plain_corr = core_prod >>> `PLAIN_CORE_SHIFT;
    wire signed [15:0] sharp_corr = core_prod >>> `SHARP_CORE_SHIFT;
    wire signed [15:0] core_term = (noise_mode_sel == NOISE_PLAIN) ?
                                   (below ? -plain_corr : 16'sh0000) :
                                   (above ? sharp_corr : 16'sh0000);

    // luma sharpness
    wire sharp_on = (luma_filter_select == `EXT_LUMA_FILTER) && sharpness_filter_enable;
    wire [3:0] sharp_code = (sharpness_select > `SHARP_MAX_CODE) ?
                            `SHARP_MAX_CODE : sharpness_select;
    wire signed [4:0] sharp_k = $signed({1'b0, sharp_code}) - `SHARP_NORMAL;
    wire signed [15:0] sharp_term = sharp_on ?
                                    16'(detail * sharp_k) >>> `SHARP_SHIFT : 16'sh0000;

    // brightness
    wire signed [7:0] bright_raw = {brightness_offset[6], brightness_offset[6:0]};
    wire signed [7:0] bright_code = (bright_raw > `BRIGHT_MAX_CODE) ? `BRIGHT_MAX_CODE :
                                    (bright_raw < `BRIGHT_MIN_CODE) ? `BRIGHT_MIN_CODE :
                                    bright_raw;
    wire signed [15:0] bright_term = 16'(bright_code) <<< `BRIGHT_SHIFT;
    wire signed [15:0] luma_sum = $signed({6'h00, head.y}) + core_term + sharp_term +
                                  bright_term;
    wire [9:0] luma_out = (luma_sum < 16'sh0000) ? 10'h000 :
                          (luma_sum > 16'sh03FF) ? 10'h3FF : luma_sum[9:0];

    // colour gains
    wire signed [18:0] u_prod = head.u * $signed({1'b0, u_gain});
    wire signed [18:0] v_prod = head.v * $signed({1'b0, v_gain});
    wire signed [9:0] u_out = clamp_signed(u_prod >>> `GAIN_SHIFT);
    wire signed [9:0] v_out = clamp_signed(v_prod >>> `GAIN_SHIFT);

    // hue: chroma phase offset during active video only
    wire signed [8:0] hue_phase = head.active ?
                                  $signed({1'b0, hue_shift}) - `HUE_ZERO : 9'sh000;

    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (fire) begin
            out_valid <= 1'b1;
            out_data.active <= head.active;
            out_data.y <= luma_out;
            out_data.u <= u_out;
            out_data.v <= v_out;
            out_data.chroma_phase <= hue_phase;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    a_pace_gap: assert property (@(posedge clk) disable iff (rst)
        pix_en |=> !pix_en) else $error("pixel enable repeated");

    a_fire_pace: assert property (@(posedge clk) disable iff (rst)
        fire |-> pix_en ##1 !fire) else $error("pixel taken off pace");

    a_u_unity: assert property (@(posedge clk) disable iff (rst)
        fire && u_gain == 8'h80 |=> out_data.u == $past(head.u))
        else $error("unity u gain altered u");

    a_v_zero: assert property (@(posedge clk) disable iff (rst)
        fire && v_gain == 8'h00 |=> out_data.v == 10'sh000)
        else $error("zero v gain left v");

    a_hue_burst: assert property (@(posedge clk) disable iff (rst)
        fire && !head.active |=> out_data.chroma_phase == 9'sh000)
        else $error("hue shift outside active video");

    a_hue_offset: assert property (@(posedge clk) disable iff (rst)
        fire && head.active |=>
        out_data.chroma_phase == $signed({1'b0, $past(hue_shift)}) - 9'sh080)
        else $error("hue offset not code minus 128");

    a_luma_clean: assert property (@(posedge clk) disable iff (rst)
        fire && noise_coring_gains == 8'h00 && !sharp_on && brightness_offset == 8'h00
        |=> out_data.y == $past(head.y)) else $error("luma altered at neutral");

    a_sharp_normal: assert property (@(posedge clk) disable iff (rst)
        fire && sharp_on && sharpness_select == 4'h6 && noise_coring_gains == 8'h00
        && brightness_offset == 8'h00 |=> out_data.y == $past(head.y))
        else $error("normal sharpness altered luma");

    a_block_wrap: assert property (@(posedge clk) disable iff (rst)
        col_r < block_size || $changed(block_size))
        else $error("column beyond block size");

    a_plain_thresh: assert property (@(posedge clk) disable iff (rst)
        fire && noise_mode_sel == NOISE_PLAIN && threshold == 6'h00 && !sharp_on
        && brightness_offset == 8'h00 |=> out_data.y == $past(head.y))
        else $error("plain coring above threshold");
endmodule

// ===== shared/video_adjust_defines.svh
`ifndef VIDEO_ADJUST_DEFINES_SVH
`define VIDEO_ADJUST_DEFINES_SVH

// register subaddresses
`define OFS_U_GAIN 6'h1E
`define OFS_V_GAIN 6'h1F
`define OFS_HUE_SHIFT 6'h20
`define OFS_BRIGHTNESS 6'h21
`define OFS_SHARPNESS 6'h22
`define OFS_CORING_GAINS 6'h23
`define OFS_THRESHOLD_BLOCK 6'h24
`define OFS_NOISE_MODE 6'h25

// reset values
`define RST_U_GAIN 8'h80
`define RST_V_GAIN 8'h80
`define RST_HUE_SHIFT 8'h80
`define RST_BRIGHTNESS 8'h00
`define RST_SHARPNESS 4'h6
`define RST_CORING_GAINS 8'h00
`define RST_THRESHOLD_BLOCK 8'h00
`define RST_NOISE_MODE 1'b0

// field positions
`define BORDER_GAIN_LSB 0
`define INNER_GAIN_LSB 4
`define THRESHOLD_LSB 0
`define BORDER_WIDTH_BIT 6
`define BLOCK_SIZE_BIT 7
`define NOISE_MODE_BIT 3

// arithmetic constants
`define GAIN_SHIFT 7
`define HUE_ZERO 9'sh080
`define BRIGHT_MAX_CODE 8'sh1E
`define BRIGHT_MIN_CODE 8'shF1
`define BRIGHT_SHIFT 2
`define SHARP_NORMAL 5'sh06
`define SHARP_MAX_CODE 4'hC
`define EXT_LUMA_FILTER 3'h4
`define CORE_GAIN_MAX 4'h8
`define PLAIN_CORE_SHIFT 3
`define SHARP_CORE_SHIFT 4
`define SHARP_SHIFT 3
`define SMALL_BLOCK 5'h08
`define LARGE_BLOCK 5'h10

// timing: one pixel spans two clocks
`define CLKS_PER_PIXEL 2

`endif

// ===== shared/video_adjust_pkg.sv
package video_adjust_pkg;

typedef enum logic {
    NOISE_PLAIN = 1'b0,
    NOISE_SHARP = 1'b1
} noise_mode_t;

typedef struct packed {
    logic frame_start;
    logic line_start;
    logic active;
    logic [9:0] y;
    logic signed [9:0] u;
    logic signed [9:0] v;
} video_in_t;

typedef struct packed {
    logic active;
    logic [9:0] y;
    logic signed [9:0] u;
    logic signed [9:0] v;
    logic signed [8:0] chroma_phase;
} video_out_t;

endpackage

// ===== tb/video_adjust_and_noise_reduction_test.sv
`timescale 1ns/1ps
`include "video_adjust_defines.svh"
module video_adjust_and_noise_reduction_test;
    import video_adjust_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] luma_filter_select = 3'h0;
    logic sharpness_filter_enable = 1'b0;
    logic in_valid;
    logic in_ready;
    logic out_valid;
    logic out_ready = 1'b1;
    video_in_t in_data;
    video_out_t out_data;
    video_out_t expect_q[$];
    int n_fail = 0;
    int comparisons = 0;
    int ready_mode = 0;
    logic [31:0] lfsr_state = 32'h1216;
    logic [7:0] cur_u = 8'h80;
    logic [7:0] cur_v = 8'h80;
    logic [7:0] cur_hue = 8'h80;
    logic [7:0] cur_br = 8'h00;
    logic [7:0] rst_vals [8] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00};
    logic [7:0] cfg [5][4] = '{'{8'h80, 8'h80, 8'h80, 8'h00}, '{8'h00, 8'hFF, 8'h00, 8'h1E},
        '{8'h97, 8'h40, 8'hFF, 8'h71}, '{8'hFF, 8'h00, 8'h97, 8'h0F},
        '{8'hC0, 8'hC0, 8'h69, 8'h72}};

    video_adjust_and_noise_reduction #(.FIFO_DEPTH(32)) DUT (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
        .luma_filter_select(luma_filter_select),
        .sharpness_filter_enable(sharpness_filter_enable), .in_valid(in_valid),
        .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready));
    video_source_model src (.clk(clk), .in_ready(in_ready), .in_valid(in_valid),
        .in_data(in_data));

    initial begin
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        lfsr_state = {lfsr_state[30:0],
            lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        return lfsr_state;
    endfunction

    function automatic int clip(input int x, input int lo, input int hi);
        return (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction

    function automatic video_out_t model_px(input video_in_t p);
        video_out_t e;
        int b;
        b = cur_br[6] ? int'(cur_br[6:0]) - 128 : int'(cur_br[6:0]);
        b = clip(b, -15, 30);
        e.active = p.active;
        e.y = 10'(clip(int'(p.y) + b * 4, 0, 1023));
        e.u = 10'(clip((int'(p.u) * int'(cur_u)) >>> `GAIN_SHIFT, -512, 511));
        e.v = 10'(clip((int'(p.v) * int'(cur_v)) >>> `GAIN_SHIFT, -512, 511));
        e.chroma_phase = p.active ? 9'(int'(cur_hue) - 128) : 9'h000;
        return e;
    endfunction

    task automatic fail(input string msg);
        n_fail++;
        $display("MISMATCH t=%0t %s", $time, msg);
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) fail($sformatf("byte got %h want %h", got, exp));
    endtask

    task automatic check_pixel(input video_out_t exp);
        comparisons++;
        if (out_data !== exp) fail($sformatf("pixel got %h want %h", out_data, exp));
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(negedge clk);
        reg_we = 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        check8(reg_rdata, e);
    endtask

    task automatic push_px(input logic first, input int tries, output logic ok);
        video_in_t p;
        logic [31:0] r;
        r = rnd();
        p.frame_start = first;
        p.line_start = first;
        p.active = 1'b1;
        p.y = r[9:0];
        p.u = r[19:10];
        p.v = r[29:20];
        src.send(p, int'(r[31]), tries, ok);
        if (ok) expect_q.push_back(model_px(p));
    endtask

    task automatic drain();
        int n;
        for (n = 0; n < 3000 && expect_q.size() != 0; n++) @(negedge clk);
        if (expect_q.size() != 0) begin
            fail("output stalled");
            print_verdict();
        end
    endtask

    always @(negedge clk) begin
        out_ready <= (ready_mode == 0) || (ready_mode == 1 && (rnd() & 32'h3) != 32'h0);
    end

    always @(posedge clk) begin
        if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (expect_q.size() == 0) fail("unexpected pixel");
            else check_pixel(expect_q.pop_front());
        end
    end

    initial begin
        int i;
        int k;
        int acc;
        logic ok;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 8; i++) rd(6'h1E + 6'(i), rst_vals[i]);
        wr(6'h3F, 8'hFF);
        rd(6'h3F, 8'h00);
        wr(`OFS_SHARPNESS, 8'hFF);
        rd(`OFS_SHARPNESS, 8'h0F);
        wr(`OFS_CORING_GAINS, 8'hA5);
        rd(`OFS_CORING_GAINS, 8'hA5);
        wr(`OFS_THRESHOLD_BLOCK, 8'hFF);
        rd(`OFS_THRESHOLD_BLOCK, 8'hFF);
        wr(`OFS_CORING_GAINS, 8'h00);
        wr(`OFS_THRESHOLD_BLOCK, 8'h00);
        wr(`OFS_NOISE_MODE, 8'h08);
        // brightness codes stay clear of 3F..44 hex
        for (i = 0; i < 5; i++) begin
            cur_u = cfg[i][0];
            cur_v = cfg[i][1];
            cur_hue = cfg[i][2];
            cur_br = cfg[i][3];
            for (k = 0; k < 4; k++) wr(6'h1E + 6'(k), cfg[i][k]);
            rd(`OFS_HUE_SHIFT, cur_hue);
            wr(`OFS_SHARPNESS, (i % 3 == 2) ? 8'h06 : 8'h0C);
            luma_filter_select = (i % 3 == 1) ? 3'h3 : `EXT_LUMA_FILTER;
            sharpness_filter_enable = (i % 3 != 0);
            ready_mode = 1;
            for (k = 0; k < 6; k++) begin
                push_px(k == 0, 400, ok);
                if (!ok) fail("input refused");
            end
            src.idle();
            drain();
        end
        ready_mode = 2;
        repeat (3) @(negedge clk);
        acc = 0;
        ok = 1'b1;
        for (k = 0; k < 40 && ok; k++) begin
            push_px(k == 0, 4, ok);
            if (ok) acc++;
        end
        src.idle();
        check8((acc >= 32 && !ok) ? 8'h01 : 8'h00, 8'h01);
        check8({7'h00, in_ready}, 8'h00);
        ready_mode = 1;
        drain();
        check8({7'h00, in_ready}, 8'h01);
        print_verdict();
    end
endmodule

// ===== tb/video_source_model.sv
`timescale 1ns/1ps
module video_source_model
    import video_adjust_pkg::*;
(
    input wire logic clk,
    input wire logic in_ready,
    output logic in_valid,
    output video_in_t in_data
);
    initial begin
        in_valid = 1'b0;
        in_data = '0;
    end
    // holds each pixel until an edge samples in_ready high, giving up after tries edges
    task automatic send(input video_in_t px, input int gap, input int tries, output logic ok);
        int n;
        ok = 1'b0;
        @(negedge clk);
        if (gap > 0) begin
            in_valid = 1'b0;
            in_data = ~in_data;
            repeat (gap) @(negedge clk);
        end
        in_valid = 1'b1;
        in_data = px;
        for (n = 0; n < tries && !ok; n++) begin
            @(posedge clk);
            ok = in_ready;
        end
    endtask
    // released bus shows scrambled data
    task automatic idle();
        @(negedge clk);
        in_valid = 1'b0;
        in_data = ~in_data;
    endtask
endmodule
